// ---- rtl/ccd_pkg.sv ----
package ccd_pkg;
   // ==========================================
   // Flag positions and reset values
   localparam int         FLAG_C     = 0;
   localparam int         FLAG_Z     = 1;
   localparam int         FLAG_S     = 2;
   localparam int         FLAG_V     = 3;
   localparam logic [3:0] FLAGS_RST  = 4'h0;
   localparam logic [7:0] INTERRUPT_CONTROL_REG_RST = 8'h00;
   localparam int         IRQ_EN_BIT = 7;
   // ==========================================
   // Condition codes
   localparam logic [3:0] CC_NEVER              = 4'h0;
   localparam logic [3:0] CC_SIGNED_BELOW       = 4'h1;
   localparam logic [3:0] CC_SIGNED_AT_MOST     = 4'h2;
   localparam logic [3:0] CC_UNSIGNED_AT_MOST   = 4'h3;
   localparam logic [3:0] CC_V_FLAG_SET         = 4'h4;
   localparam logic [3:0] CC_SIGN_SET           = 4'h5;
   localparam logic [3:0] CC_OPERANDS_SAME      = 4'h6;
   localparam logic [3:0] CC_UNSIGNED_BELOW     = 4'h7;
   localparam logic [3:0] CC_ALWAYS             = 4'h8;
   localparam logic [3:0] CC_SIGNED_AT_LEAST    = 4'h9;
   localparam logic [3:0] CC_SIGNED_ABOVE       = 4'hA;
   localparam logic [3:0] CC_UNSIGNED_ABOVE     = 4'hB;
   localparam logic [3:0] CC_V_FLAG_CLEAR       = 4'hC;
   localparam logic [3:0] CC_SIGN_CLEAR         = 4'hD;
   localparam logic [3:0] CC_RESULT_NOT_ZERO    = 4'hE;
   localparam logic [3:0] CC_UNSIGNED_AT_LEAST  = 4'hF;
   // ==========================================
   // Opcodes and columns
   localparam logic [7:0] OPC_PREFIX_2ND = 8'h1F;
   localparam logic [7:0] OPC_CMP_FIRST  = 8'hA2;
   localparam logic [7:0] OPC_CMP_LAST   = 8'hA9;
   localparam logic [3:0] COL_LOOP       = 4'hA;
   localparam logic [3:0] COL_JR         = 4'hB;
   localparam logic [2:0] PREFIX_EXTRA   = 3'h1;
   localparam logic [7:0] ONE_BYTE       = 8'h01;
   localparam logic [15:0] ONE_WORD      = 16'h0001;
   // ==========================================
   // Decoded operation classes
   typedef enum logic [4:0] {
      OP_OTHER, OP_INVERT, OP_CMP, OP_CMP_BORROW, OP_DA, OP_DEC, OP_MINUS_ONE_WORD,
      OP_IRQ_OFF, OP_IRQ_ON, OP_LOOP, OP_JR, OP_BRK, OP_SRP, OP_ADD,
      OP_PREFIX2, OP_ATOMIC, OP_IDLE, OP_WDT, OP_STOP, OP_HALT, OP_RET,
      OP_INTERRUPT_RETURN, OP_RCF, OP_SCF, OP_CCF, OP_SECOND_MAP
   } ccd_op_t;
   typedef enum logic [1:0] {ST_FIRST = 2'b01, ST_SECOND = 2'b10} ccd_state_t;

   // Byte count and execute cycles of a first-map opcode.
   function automatic logic [6:0] op_cost(input logic [7:0] b);
      logic [6:0] c;
      c = {3'h2, 4'h3};
      unique case (b[3:0])
         4'h0: c = (b == 8'h00) ? {3'h1, 4'h2} : (b == 8'h80 || b == 8'hA0) ? {3'h2, 4'h5} : {3'h2, 4'h2};
         4'h1: c = (b == 8'h01) ? {3'h2, 4'h2} : (b == 8'h81 || b == 8'hA1) ? {3'h2, 4'h6} : {3'h2, 4'h3};
         4'h2, 4'hA: c = {3'h2, 4'h3};
         4'h3: c = {3'h2, 4'h4};
         4'h4, 4'h6: c = {3'h3, 4'h3};
         4'h5, 4'h7: c = {3'h3, 4'h4};
         4'h8, 4'h9: c = {3'h4, 4'h3};
         4'hB, 4'hC: c = {3'h2, 4'h2};
         4'hD: c = {3'h3, 4'h2};
         4'hE: c = {3'h1, 4'h2};
         4'hF: c = (b == 8'hAF) ? {3'h1, 4'h4} : (b == 8'hBF) ? {3'h1, 4'h5} : {3'h1, 4'h2};
      endcase
      return c;
   endfunction
endpackage

// ---- rtl/ccd_exec_if.sv ----
`timescale 1ns/1ps
interface ccd_exec_if;
   import ccd_pkg::*;
   ccd_op_t     op;
   logic        borrow;
   logic [7:0]  dst;
   logic [15:0] word;
   logic [7:0]  src;
   logic [3:0]  flags_in;
   logic        flag_d;
   logic        flag_h;
   logic [15:0] res;
   logic [3:0]  flags_out;
   logic        res_we;
   logic [3:0]  cc;
   logic        cc_true;
   modport core (output op, borrow, dst, word, src, flags_in, flag_d, flag_h, cc,
                 input res, flags_out, res_we, cc_true);
   modport alu  (input op, borrow, dst, word, src, flags_in, flag_d, flag_h,
                 output res, flags_out, res_we);
   modport cond (input flags_in, cc, output cc_true);
endinterface

// ---- rtl/ccd_cond.sv ----
`timescale 1ns/1ps
module ccd_cond
   import ccd_pkg::*;
(
   ccd_exec_if.cond ex
);
   logic c, z, s, v, sv;
   assign c  = ex.flags_in[FLAG_C];
   assign z  = ex.flags_in[FLAG_Z];
   assign s  = ex.flags_in[FLAG_S];
   assign v  = ex.flags_in[FLAG_V];
   assign sv = s ^ v;
   always_comb begin
      unique case (ex.cc)
         CC_NEVER:             ex.cc_true = 1'b0;
         CC_SIGNED_BELOW:      ex.cc_true = sv;
         CC_SIGNED_AT_MOST:    ex.cc_true = z | sv;
         CC_UNSIGNED_AT_MOST:  ex.cc_true = c | z;
         CC_V_FLAG_SET:        ex.cc_true = v;
         CC_SIGN_SET:          ex.cc_true = s;
         CC_OPERANDS_SAME:     ex.cc_true = z;
         CC_UNSIGNED_BELOW:    ex.cc_true = c;
         CC_ALWAYS:            ex.cc_true = 1'b1;
         CC_SIGNED_AT_LEAST:   ex.cc_true = ~sv;
         CC_SIGNED_ABOVE:      ex.cc_true = ~(z | sv);
         CC_UNSIGNED_ABOVE:    ex.cc_true = ~c & ~z;
         CC_V_FLAG_CLEAR:      ex.cc_true = ~v;
         CC_SIGN_CLEAR:        ex.cc_true = ~s;
         CC_RESULT_NOT_ZERO:   ex.cc_true = ~z;
         CC_UNSIGNED_AT_LEAST: ex.cc_true = ~c;
      endcase
   end
endmodule

// ---- rtl/ccd_alu.sv ----
`timescale 1ns/1ps
module ccd_alu
   import ccd_pkg::*;
(
   ccd_exec_if.alu ex
);
   logic [8:0]  diff;
   logic [7:0]  inv;
   logic [7:0]  dec1;
   logic [15:0] minus_one_word;
   logic [7:0]  da_adj;
   logic [7:0]  da_res;
   logic        lo_fix;
   logic        hi_fix;
   logic        cin;
   assign cin    = ex.borrow && ex.flags_in[FLAG_C];
   assign diff   = {1'b0, ex.dst} - {1'b0, ex.src} - {8'h00, cin};
   assign inv    = ~ex.dst;
   assign dec1   = ex.dst - ONE_BYTE;
   assign minus_one_word   = ex.word - ONE_WORD;
   assign lo_fix = ex.flag_h | (ex.dst[3:0] > 4'h9);
   assign hi_fix = ex.flags_in[FLAG_C] | (ex.dst > 8'h99);
   assign da_adj = {1'b0, hi_fix, hi_fix, 2'b00, lo_fix, lo_fix, 1'b0};
   assign da_res = ex.flag_d ? ex.dst - da_adj : ex.dst + da_adj;
   always_comb begin
      ex.res       = 16'h0000;
      ex.res_we    = 1'b0;
      ex.flags_out = ex.flags_in;
      unique case (ex.op)
         OP_INVERT: begin
            ex.res       = {8'h00, inv};
            ex.res_we    = 1'b1;
            ex.flags_out = {1'b0, inv[7], inv == 8'h00, ex.flags_in[FLAG_C]};
         end
         OP_CMP, OP_CMP_BORROW: begin
            ex.res       = {8'h00, diff[7:0]};
            ex.flags_out = {(ex.dst[7] ^ ex.src[7]) & (ex.dst[7] ^ diff[7]),
                            diff[7], diff[7:0] == 8'h00, diff[8]};
         end
         OP_DA: begin
            ex.res       = {8'h00, da_res};
            ex.res_we    = 1'b1;
            ex.flags_out = {ex.flags_in[FLAG_V], da_res[7], da_res == 8'h00, hi_fix};
         end
         OP_DEC: begin
            ex.res       = {8'h00, dec1};
            ex.res_we    = 1'b1;
            ex.flags_out = {ex.dst == 8'h80, dec1[7], dec1 == 8'h00, ex.flags_in[FLAG_C]};
         end
         OP_MINUS_ONE_WORD: begin
            ex.res       = minus_one_word;
            ex.res_we    = 1'b1;
            ex.flags_out = {ex.word == 16'h8000, minus_one_word[15], minus_one_word == 16'h0000, ex.flags_in[FLAG_C]};
         end
         OP_LOOP: begin
            ex.res    = {8'h00, dec1};
            ex.res_we = 1'b1;
         end
         OP_RCF: ex.flags_out[FLAG_C] = 1'b0;
         OP_SCF: ex.flags_out[FLAG_C] = 1'b1;
         OP_CCF: ex.flags_out[FLAG_C] = ~ex.flags_in[FLAG_C];
         default: ex.res_we = 1'b0;
      endcase
   end
endmodule

// ---- rtl/ccd_decode_top.sv ----
`timescale 1ns/1ps
// What this block does
// - Code 0011 true when carry or zero.
// - Code 0100 overflow set, 0101 sign set.
// - Code 0110 zero set, 0111 carry set.
// - Code 1000 is always true.
// - 1001 sign xor overflow clear; 1010 adds zero.
// - Code 1110 zero clear, 1111 carry clear.
// - Compare A2-A7 subtracts, updates four flags.
// - Prefixed compare subtracts carry, one more fetch.
// - A8/A9 extended compare costs four fetch, three execute.
// - Byte decrement 30/31 keeps carry.
// - Word decrement 80/81, five or six cycles.
// - 8F clears interrupt enable bit seven.
// - Column A decrements, branches if nonzero.
// - 00 breakpoint, 01 pointer set, 02-09 add.
// - Columns 2-9 carry fixed byte/cycle costs.
// - 1F selects second map; 2F atomic prefix.
// - Decimal adjust 40/41 updates carry, zero, sign.
module ccd_decode_top
   import ccd_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        OP_VALID,
   input  wire logic [7:0]  OP_BYTE,
   input  wire logic [7:0]  DST_DATA,
   input  wire logic [7:0]  SRC_DATA,
   input  wire logic [15:0] WORD_DATA,
   input  wire logic        FLAG_D_IN,
   input  wire logic        FLAG_H_IN,
   input  wire logic        FLAG_LOAD,
   input  wire logic [3:0]  FLAG_LOAD_DATA,
   output logic             DONE,
   output ccd_op_t          OP_CLASS,
   output logic [15:0]      RESULT,
   output logic             RESULT_WE,
   output logic [3:0]       FLAGS,
   output logic             COND_TRUE,
   output logic             BRANCH_TAKE,
   output logic [3:0]       REG_SEL,
   output logic [2:0]       BYTES,
   output logic [2:0]       FETCH_CYC,
   output logic [3:0]       EXEC_CYC,
   output logic [7:0]       IRQ_CTL,
   output logic             IN_PREFIX
);
   // ==========================================
   // Decode
   ccd_exec_if ex ();
   ccd_state_t state;
   ccd_state_t next_state;
   ccd_op_t    dec_op;
   logic       in_second;
   logic [6:0] cost;
   logic [2:0] next_fetch;
   logic [3:0] next_flags;
   logic [7:0] next_irq;
   logic       next_branch;
   logic       is_cmp;

   // Map one byte to an operation class.
   function automatic ccd_op_t decode_op(input logic [7:0] b, input logic second);
      ccd_op_t op;
      op = OP_OTHER;
      if (second) begin
         if (b >= OPC_CMP_FIRST && b <= OPC_CMP_LAST) begin
            op = OP_CMP_BORROW;
         end else begin
            op = OP_SECOND_MAP;
         end
      end else if (b[3:0] == COL_LOOP) begin
         op = OP_LOOP;
      end else if (b[3:0] == COL_JR) begin
         op = OP_JR;
      end else if (b >= 8'h02 && b <= 8'h09) begin
         op = OP_ADD;
      end else if (b >= OPC_CMP_FIRST && b <= OPC_CMP_LAST) begin
         op = OP_CMP;
      end else begin
         case (b)
            8'h00: op = OP_BRK;
            8'h01: op = OP_SRP;
            8'h60, 8'h61: op = OP_INVERT;
            8'h40, 8'h41: op = OP_DA;
            8'h30, 8'h31: op = OP_DEC;
            8'h80, 8'h81: op = OP_MINUS_ONE_WORD;
            8'h0F: op = OP_IDLE;
            8'h1F: op = OP_PREFIX2;
            8'h2F: op = OP_ATOMIC;
            8'h5F: op = OP_WDT;
            8'h6F: op = OP_STOP;
            8'h7F: op = OP_HALT;
            8'h8F: op = OP_IRQ_OFF;
            8'h9F: op = OP_IRQ_ON;
            8'hAF: op = OP_RET;
            8'hBF: op = OP_INTERRUPT_RETURN;
            8'hCF: op = OP_RCF;
            8'hDF: op = OP_SCF;
            8'hEF: op = OP_CCF;
            default: op = OP_OTHER;
         endcase
      end
      return op;
   endfunction

   assign in_second = state == ST_SECOND;
   assign dec_op    = decode_op(OP_BYTE, in_second);
   assign cost      = op_cost(OP_BYTE);
   assign is_cmp    = dec_op == OP_CMP || dec_op == OP_CMP_BORROW;

   // The prefixed byte pays one extra fetch for the prefix itself.
   assign next_fetch = in_second ? cost[6:4] + PREFIX_EXTRA : cost[6:4];

   assign next_state = !OP_VALID ? state :
                       (!in_second && OP_BYTE == OPC_PREFIX_2ND) ? ST_SECOND : ST_FIRST;

   // ==========================================
   // Datapath hookup
   // Conditions see the committed register, so a branch follows the
   // flags left by the instruction just before it.
   assign ex.op       = dec_op;
   assign ex.borrow   = in_second;
   assign ex.dst      = DST_DATA;
   assign ex.src      = SRC_DATA;
   assign ex.word     = WORD_DATA;
   assign ex.flags_in = FLAGS;
   assign ex.flag_d   = FLAG_D_IN;
   assign ex.flag_h   = FLAG_H_IN;
   assign ex.cc       = OP_BYTE[7:4];

   ccd_alu u_alu (
      .ex (ex)
   );

   ccd_cond u_cond (
      .ex (ex)
   );

   // Instruction flag updates win over a load from another unit in the
   // same cycle; the other unit must retry or order its load.
   assign next_flags = OP_VALID ? ex.flags_out :
                       FLAG_LOAD ? FLAG_LOAD_DATA : FLAGS;

   assign next_branch = (dec_op == OP_LOOP) ? ex.res[7:0] != 8'h00 :
                        (dec_op == OP_JR) ? ex.cc_true : 1'b0;

   assign next_irq = (OP_VALID && dec_op == OP_IRQ_OFF) ? {1'b0, IRQ_CTL[6:0]} :
                     (OP_VALID && dec_op == OP_IRQ_ON) ? {1'b1, IRQ_CTL[6:0]} : IRQ_CTL;

   // ==========================================
   // State and committed registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= ST_FIRST;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FLAGS   <= FLAGS_RST;
         IRQ_CTL <= INTERRUPT_CONTROL_REG_RST;
      end else begin
         FLAGS   <= next_flags;
         IRQ_CTL <= next_irq;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DONE      <= 1'b0;
         RESULT_WE <= 1'b0;
         IN_PREFIX <= 1'b0;
      end else begin
         DONE      <= OP_VALID;
         RESULT_WE <= OP_VALID && ex.res_we && !is_cmp;
         IN_PREFIX <= next_state == ST_SECOND;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         OP_CLASS    <= OP_OTHER;
         RESULT      <= 16'h0000;
         COND_TRUE   <= 1'b0;
         BRANCH_TAKE <= 1'b0;
         REG_SEL     <= 4'h0;
      end else if (OP_VALID) begin
         OP_CLASS    <= dec_op;
         RESULT      <= ex.res;
         COND_TRUE   <= ex.cc_true;
         BRANCH_TAKE <= next_branch;
         REG_SEL     <= OP_BYTE[7:4];
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         BYTES     <= 3'h0;
         FETCH_CYC <= 3'h0;
         EXEC_CYC  <= 4'h0;
      end else if (OP_VALID) begin
         BYTES     <= cost[6:4];
         FETCH_CYC <= next_fetch;
         EXEC_CYC  <= cost[3:0];
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   logic first_ok;
   assign first_ok = OP_VALID && !in_second;

   a_unsigned_at_most: assert property (
      ex.cc == CC_UNSIGNED_AT_MOST |-> ex.cc_true == (FLAGS[FLAG_C] | FLAGS[FLAG_Z]))
      else $error("unsigned at-most evaluated wrong");

   a_sign_set_eval: assert property (
      ex.cc == CC_SIGN_SET |-> ex.cc_true == FLAGS[FLAG_S])
      else $error("sign-set condition wrong");

   a_carry_set_eval: assert property (
      ex.cc == CC_UNSIGNED_BELOW |-> ex.cc_true == FLAGS[FLAG_C])
      else $error("carry-set condition wrong");

   a_always_true: assert property (
      first_ok && OP_BYTE == 8'h8B |=> BRANCH_TAKE && COND_TRUE)
      else $error("always condition did not branch");

   a_signed_above: assert property (
      ex.cc == CC_SIGNED_ABOVE |->
      ex.cc_true == !(FLAGS[FLAG_Z] | (FLAGS[FLAG_S] ^ FLAGS[FLAG_V])))
      else $error("signed above wrong");

   a_unsigned_above: assert property (
      ex.cc == CC_UNSIGNED_ABOVE && (FLAGS[FLAG_C] || FLAGS[FLAG_Z]) |-> !ex.cc_true)
      else $error("unsigned above true with carry or zero");

   a_v_clear_eval: assert property (
      ex.cc == CC_V_FLAG_CLEAR |-> ex.cc_true != FLAGS[FLAG_V])
      else $error("overflow-clear condition wrong");

   a_not_zero_eval: assert property (
      ex.cc == CC_RESULT_NOT_ZERO |-> ex.cc_true != FLAGS[FLAG_Z])
      else $error("not-zero condition wrong");

   a_invert_flags: assert property (
      first_ok && OP_BYTE == 8'h60 |=>
      !FLAGS[FLAG_V] && FLAGS[FLAG_C] == $past(FLAGS[FLAG_C]) && RESULT[7:0] == ~$past(DST_DATA))
      else $error("invert flags or result wrong");

   a_compare_carry: assert property (
      first_ok && OP_BYTE == 8'hA2 |=> FLAGS[FLAG_C] == ($past(DST_DATA) < $past(SRC_DATA)))
      else $error("compare borrow wrong");

   a_prefix_fetch: assert property (
      OP_VALID && in_second && OP_BYTE == 8'hA2 |=> FETCH_CYC == 3'h3 && OP_CLASS == OP_CMP_BORROW)
      else $error("prefixed compare cost wrong");

   a_cmp_borrow_carry: assert property (
      OP_VALID && in_second && OP_BYTE == 8'hA2 |=>
      FLAGS[FLAG_C] == ({1'b0, $past(DST_DATA)} < {1'b0, $past(SRC_DATA)} + {8'h00, $past(FLAGS[FLAG_C])}))
      else $error("prefixed compare borrow wrong");

   a_ext_cost: assert property (
      first_ok && OP_BYTE == 8'hA8 |=> FETCH_CYC == 3'h4 && EXEC_CYC == 4'h3)
      else $error("extended compare cost wrong");

   a_dec_keeps_carry: assert property (
      first_ok && OP_BYTE == 8'h30 |=> FLAGS[FLAG_C] == $past(FLAGS[FLAG_C]) && RESULT_WE)
      else $error("byte decrement touched carry");

   a_dec_result: assert property (
      first_ok && OP_BYTE == 8'h31 |=> RESULT[7:0] == $past(DST_DATA) - ONE_BYTE && RESULT_WE)
      else $error("byte decrement result wrong");

   a_minus_one_word_cycles: assert property (
      first_ok && OP_BYTE == 8'h81 |=> EXEC_CYC == 4'h6 && RESULT == $past(WORD_DATA) - ONE_WORD)
      else $error("word decrement wrong");

   a_irq_off: assert property (
      first_ok && OP_BYTE == 8'h8F |=> !IRQ_CTL[IRQ_EN_BIT] && FLAGS == $past(FLAGS) && EXEC_CYC == 4'h2)
      else $error("interrupt off failed");

   a_loop_branch: assert property (
      first_ok && OP_BYTE[3:0] == COL_LOOP |=>
      BRANCH_TAKE == ($past(DST_DATA) != ONE_BYTE) && FLAGS == $past(FLAGS))
      else $error("loop branch wrong");

   a_brk_cost: assert property (
      first_ok && OP_BYTE == 8'h00 |=> OP_CLASS == OP_BRK && BYTES == 3'h1 && EXEC_CYC == 4'h2)
      else $error("breakpoint decode wrong");

   a_column_cost: assert property (
      first_ok && OP_BYTE[3:0] == 4'h3 |=> BYTES == 3'h2 && EXEC_CYC == 4'h4)
      else $error("column cost wrong");

   a_prefix_enter: assert property (
      first_ok && OP_BYTE == OPC_PREFIX_2ND |=> (IN_PREFIX and (OP_VALID |=> !IN_PREFIX)))
      else $error("second map prefix wrong");

   a_ret_cycles: assert property (
      first_ok && OP_BYTE == 8'hBF |=> OP_CLASS == OP_INTERRUPT_RETURN && EXEC_CYC == 4'h5)
      else $error("interrupt return decode wrong");

   a_irq_on: assert property (
      first_ok && OP_BYTE == 8'h9F |=> IRQ_CTL[IRQ_EN_BIT] && FLAGS == $past(FLAGS))
      else $error("interrupt on failed");

   a_da_keeps_v: assert property (
      first_ok && OP_BYTE == 8'h40 |=> OP_CLASS == OP_DA && RESULT_WE && FLAGS[FLAG_V] == $past(FLAGS[FLAG_V]))
      else $error("decimal adjust not written");

   a_cmp_no_write: assert property (
      DONE && (OP_CLASS == OP_CMP || OP_CLASS == OP_CMP_BORROW) |-> !RESULT_WE)
      else $error("compare wrote back");

   a_branch_flags: assert property (
      first_ok && OP_BYTE == 8'h6B |=> BRANCH_TAKE == $past(FLAGS[FLAG_Z]))
      else $error("branch used stale flags");

   a_flag_load: assert property (
      !OP_VALID && FLAG_LOAD |=> FLAGS == $past(FLAG_LOAD_DATA))
      else $error("flag load not committed");

   c_compare_then_jump: cover property (
      first_ok && OP_BYTE == 8'hA2 ##[1:2] first_ok && OP_BYTE[3:0] == COL_JR);
   c_prefixed_compare: cover property (
      first_ok && OP_BYTE == OPC_PREFIX_2ND ##[1:2] OP_VALID && OP_BYTE == 8'hA9);
   c_irq_toggle: cover property (
      first_ok && OP_BYTE == 8'h9F ##[1:2] first_ok && OP_BYTE == 8'h8F);
   c_loop_falls_out: cover property (
      first_ok && OP_BYTE[3:0] == COL_LOOP && DST_DATA == ONE_BYTE);
endmodule

// ---- tb/ccd_fetch_model.sv ----
`timescale 1ns/1ps
module ccd_fetch_model (
   input  wire logic  clk,
   output logic       op_valid,
   output logic [7:0] op_byte,
   output logic [7:0] dst,
   output logic [7:0] src,
   output logic [15:0] word,
   output logic       flag_load,
   output logic [3:0] flag_data
);
   initial begin
      op_valid = 1'b0;
      op_byte = 8'h00;
      dst = 8'h00;
      src = 8'h00;
      word = 16'h0000;
      flag_load = 1'b0;
      flag_data = 4'h0;
   end
   // ==========================================
   // Offers
   // Operands outside an offer are inverted, so late sampling reads garbage.
   task automatic send(input logic [7:0] b, input logic [7:0] d, input logic [7:0] s, input logic [15:0] w);
      @(posedge clk);
      op_valid <= 1'b1;
      op_byte <= b;
      dst <= d;
      src <= s;
      word <= w;
      @(posedge clk);
      op_valid <= 1'b0;
      op_byte <= ~b;
      dst <= ~d;
      src <= ~s;
      word <= ~w;
   endtask
   task automatic load(input logic [3:0] f);
      @(posedge clk);
      flag_load <= 1'b1;
      flag_data <= f;
      @(posedge clk);
      flag_load <= 1'b0;
      flag_data <= ~f;
   endtask
endmodule

// ---- tb/ccd_decode_top_tb.sv ----
`timescale 1ns/1ps
module ccd_decode_top_tb
   import ccd_pkg::*;
;
   logic        CLK = 1'b0;
   logic        RESET_N = 1'b0;
   logic        v, fl, done, we, ct, bt, irq7, pre;
   logic        dflag = 1'b0, hflag = 1'b0;
   logic [7:0]  ob, dd, sd, irq;
   logic [15:0] wd, res;
   logic [3:0]  fv, flags, rs, ec;
   logic [2:0]  nb, fc;
   ccd_op_t     opc;
   int          errors = 0;
   int          checks_done = 0;
   logic [6:0]  arith [8] = '{7'h23, 7'h24, 7'h33, 7'h34, 7'h33, 7'h34, 7'h43, 7'h43};
   always #25 CLK = ~CLK;
   ccd_fetch_model u_ccd_fetch_model (.clk(CLK), .op_valid(v), .op_byte(ob), .dst(dd), .src(sd), .word(wd),
      .flag_load(fl), .flag_data(fv));
   ccd_decode_top u_ccd_decode_top (.CLK(CLK), .RESET_N(RESET_N), .OP_VALID(v), .OP_BYTE(ob), .DST_DATA(dd),
      .SRC_DATA(sd), .WORD_DATA(wd), .FLAG_D_IN(dflag), .FLAG_H_IN(hflag), .FLAG_LOAD(fl), .FLAG_LOAD_DATA(fv),
      .DONE(done), .OP_CLASS(opc), .RESULT(res), .RESULT_WE(we), .FLAGS(flags), .COND_TRUE(ct),
      .BRANCH_TAKE(bt), .REG_SEL(rs), .BYTES(nb), .FETCH_CYC(fc), .EXEC_CYC(ec), .IRQ_CTL(irq), .IN_PREFIX(pre));
   assign irq7 = irq[7];
   // ==========================================
   // Helpers
   task automatic end_of_test;
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic run(input logic [7:0] b, input logic [7:0] d, input logic [7:0] s, input logic [15:0] w);
      int n;
      u_ccd_fetch_model.send(b, d, s, w);
      #1;
      n = 0;
      while (done !== 1'b1 && n < 4) begin
         @(posedge CLK);
         #1;
         n++;
      end
      if (done !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask
   task automatic op_chk(input logic [7:0] b, input ccd_op_t cls, input logic [6:0] cost);
      run(b, 8'h02, 8'h01, 16'h0002);
      chk(16'(opc), 16'(cls));
      chk(16'({nb, ec}), 16'(cost));
      chk(16'(fc), 16'(cost[6:4]));
   endtask
   function automatic logic cond_exp(input logic [3:0] cc, input logic [3:0] f);
      logic c, z, s, vv, n;
      logic [15:0] t;
      c = f[FLAG_C];
      z = f[FLAG_Z];
      s = f[FLAG_S];
      vv = f[FLAG_V];
      n = s ^ vv;
      t = {~c, ~z, ~s, ~vv, ~(c | z), ~(z | n), ~n, 1'b1, c, z, s, vv, c | z, z | n, n, 1'b0};
      return t[cc];
   endfunction
   // ==========================================
   // Sequence
   initial begin
      repeat (16) @(posedge CLK);
      RESET_N <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         for (int f = 0; f < 16; f++) begin
            u_ccd_fetch_model.load(f[3:0]);
            run({c[3:0], COL_JR}, 8'h00, 8'h00, 16'h0000);
            chk(16'(ct), 16'(cond_exp(c[3:0], f[3:0])));
            chk(16'(bt), 16'(cond_exp(c[3:0], f[3:0])));
         end
      end
      u_ccd_fetch_model.load(4'h0);
      run(8'hA2, 8'h05, 8'h07, 16'h0000);
      chk(16'({opc, flags}), 16'({OP_CMP, 4'h5}));
      chk(16'(we), 16'h0000);
      run(8'hA4, 8'h33, 8'h33, 16'h0000);
      chk(16'({we, flags}), 16'h0002);
      u_ccd_fetch_model.load(4'h1);
      run(OPC_PREFIX_2ND, 8'h00, 8'h00, 16'h0000);
      chk(16'(pre), 16'h0001);
      run(8'hA2, 8'h05, 8'h04, 16'h0000);
      chk(16'({opc, flags, we, pre, fc}), 16'({OP_CMP_BORROW, 4'h2, 2'b00, 3'h3}));
      op_chk(8'hA8, OP_CMP, 7'h43);
      run(OPC_PREFIX_2ND, 8'h00, 8'h00, 16'h0000);
      run(8'hA9, 8'h01, 8'h01, 16'h0000);
      chk(16'({opc, fc, ec}), 16'({OP_CMP_BORROW, 3'h5, 4'h3}));
      u_ccd_fetch_model.load(4'h9);
      run(8'h60, 8'h0F, 8'h00, 16'h0000);
      chk(16'({we, res[7:0], flags}), 16'({1'b1, 8'hF0, 4'h5}));
      run(8'h30, 8'h80, 8'h00, 16'h0000);
      chk(16'({we, res[7:0], flags}), 16'({1'b1, 8'h7F, 4'h9}));
      run(8'h31, 8'h01, 8'h00, 16'h0000);
      chk(16'({res[7:0], flags}), 16'h0003);
      run(8'h80, 8'h00, 8'h00, 16'h8000);
      chk(res, 16'h7FFF);
      chk(16'({flags, ec}), 16'h0095);
      run(8'h81, 8'h00, 8'h00, 16'h0001);
      chk(16'({res, flags, ec}), 16'h0036);
      @(posedge CLK);
      dflag <= 1'b1;
      hflag <= 1'b1;
      run(8'h41, 8'h48, 8'h00, 16'h0000);
      chk(16'({we, res[7:0], flags}), 16'({1'b1, 8'hE2, 4'h5}));
      @(posedge CLK);
      dflag <= 1'b0;
      u_ccd_fetch_model.load(4'h0);
      run(8'h40, 8'h9A, 8'h00, 16'h0000);
      chk(16'({we, res[7:0], flags}), 16'({1'b1, 8'h00, 4'h3}));
      run(8'h9F, 8'h00, 8'h00, 16'h0000);
      chk(16'(irq7), 16'h0001);
      run(8'h8F, 8'h00, 8'h00, 16'h0000);
      chk(16'({irq7, flags, fc, ec}), 16'({1'b0, 4'h3, 3'h1, 4'h2}));
      u_ccd_fetch_model.load(4'h6);
      run(8'h5A, 8'h02, 8'h00, 16'h0000);
      chk(16'({bt, rs, res[7:0], flags}), 16'({1'b1, 4'h5, 8'h01, 4'h6}));
      run(8'h5A, 8'h01, 8'h00, 16'h0000);
      chk(16'({bt, res[7:0], flags}), 16'({1'b0, 8'h00, 4'h6}));
      run(8'hDF, 8'h00, 8'h00, 16'h0000);
      chk(16'(flags), 16'h0007);
      run(8'hCF, 8'h00, 8'h00, 16'h0000);
      chk(16'(flags), 16'h0006);
      run(8'hEF, 8'h00, 8'h00, 16'h0000);
      chk(16'(flags), 16'h0007);
      for (int i = 0; i < 8; i++) begin
         op_chk(8'h02 + 8'(i), OP_ADD, arith[i]);
         op_chk(8'hA2 + 8'(i), OP_CMP, arith[i]);
      end
      op_chk(8'h00, OP_BRK, 7'h12);
      op_chk(8'h01, OP_SRP, 7'h22);
      op_chk(8'h2F, OP_ATOMIC, 7'h12);
      op_chk(8'h0F, OP_IDLE, 7'h12);
      op_chk(8'h5F, OP_WDT, 7'h12);
      op_chk(8'h6F, OP_STOP, 7'h12);
      op_chk(8'h7F, OP_HALT, 7'h12);
      op_chk(8'hAF, OP_RET, 7'h14);
      op_chk(8'hBF, OP_INTERRUPT_RETURN, 7'h15);
      op_chk(8'h3B, OP_JR, 7'h22);
      op_chk(8'h7A, OP_LOOP, 7'h23);
      op_chk(8'h80, OP_MINUS_ONE_WORD, 7'h25);
      op_chk(8'h81, OP_MINUS_ONE_WORD, 7'h26);
      op_chk(8'h9F, OP_IRQ_ON, 7'h12);
      run(OPC_PREFIX_2ND, 8'h00, 8'h00, 16'h0000);
      run(8'h30, 8'h00, 8'h00, 16'h0000);
      chk(16'({opc, fc, pre}), 16'({OP_SECOND_MAP, 3'h3, 1'b0}));
      run(OPC_PREFIX_2ND, 8'h00, 8'h00, 16'h0000);
      @(posedge CLK);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      chk(16'({irq, flags, pre}), 16'h0000);
      end_of_test();
   end
endmodule
